// ===== hdl/sdcl_pkg.sv
/*
 * Shared constants for the synchronous DRAM command link: command codes,
 * mode word fields and timing counts.
 * Assumes one 125 MHz clock shared by controller and memory.
 */
`default_nettype none

package sdcl_pkg;

    // ************************************************************
    // command codes {cs_n, ras_n, cas_n, we_n}
    // ************************************************************
    typedef enum logic [3:0] {
        SDCL_MRS = 4'h0,
        SDCL_REF = 4'h1,
        SDCL_PRE = 4'h2,
        SDCL_ACT = 4'h3,
        SDCL_WR = 4'h4,
        SDCL_RD = 4'h5,
        SDCL_BST = 4'h6,
        SDCL_NOP = 4'h7
    } sdcl_cmd_t;

    // ************************************************************
    // mode word and address fields
    // ************************************************************
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam int AP_BIT = 10;
    localparam logic [2:0] MODE_BL_FULL = 3'h7;
    localparam logic [2:0] CL_RESET = 3'h3;
    localparam logic [2:0] BL_RESET = 3'h0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int T_RCD_NS = 16;
    localparam int T_RC_NS = 72;
    localparam int T_RP_NS = 24;
    localparam int T_MRD_NS = 16;
    localparam int T_WR_CL3_NS = CLK_PERIOD_NS;
    localparam int T_WR_CL2_NS = 10;
    localparam int REF_PERIOD_MS = 32;
    localparam int REF_ROWS = 2048;

    localparam int RCD_CYC = ns_to_cyc(T_RCD_NS);
    localparam int ROW_CYCLE_INTERVAL_CYC = ns_to_cyc(T_RC_NS);
    localparam int RP_CYC = ns_to_cyc(T_RP_NS);
    localparam int MRD_CYC = ns_to_cyc(T_MRD_NS);
    localparam int WR_CL3_CYC = ns_to_cyc(T_WR_CL3_NS);
    localparam int WR_CL2_CYC = ns_to_cyc(T_WR_CL2_NS);
    // longest spacing between refreshes, rounded down
    localparam int REF_INTERVAL_CYC =
        (REF_PERIOD_MS * 1000000 / REF_ROWS) / CLK_PERIOD_NS;

    localparam int MASK_READ_DISABLE_LATENCY = 2;
    localparam int MASK_WRITE_LATENCY = 0;
    localparam int COLUMN_COMMAND_SPACING = 1;
    localparam int SREX_EDGE = 2;

endpackage

`default_nettype wire

// ===== hdl/sdcl_if.sv
/*
 * Pin bundle between controller and memory.
 * The shared data bus is resolved here per byte lane from the enables;
 * an undriven lane reads as zero.
 */
`default_nettype none

interface sdcl_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [10:0] addr;
    logic [3:0] dqm;
    logic [31:0] dq_c;
    logic dq_c_oe;
    logic [31:0] dq_m;
    logic [3:0] dq_m_oe;
    logic [31:0] dq;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dq_m_oe[i]) begin
                dq[8*i +: 8] = dq_m[8*i +: 8];
            end else if (dq_c_oe) begin
                dq[8*i +: 8] = dq_c[8*i +: 8];
            end else begin
                dq[8*i +: 8] = 8'h00;
            end
        end
    end

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_c, dq_c_oe,
        input dq
    );
    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
        output dq_m, dq_m_oe
    );
endinterface

`default_nettype wire

// ===== hdl/sdcl_fifo.sv
/*
 * Request buffer with valid/ready on both sides.
 * Assumes DEPTH is a power of two.
 */
`default_nettype none

module sdcl_fifo #(
    parameter int WIDTH = 58,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    always_comb begin
        in_ready = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
        out_valid = wp_q != rp_q;
        out_data = mem[rp_q[AW-1:0]];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule

`default_nettype wire

// ===== hdl/sdcl_mem.sv
/*
 * Memory end of the link: decodes commands, holds a small store,
 * bursts reads and writes, masks bytes and handles self refresh.
 * Assumes the controller keeps its own timing; rows are not modelled,
 * the store is indexed by bank and low column bits only.
 */
`default_nettype none

module sdcl_mem #(
    parameter int COL_BITS = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    sdcl_if.mem bus
);
    localparam int IW = COL_BITS + 2;

    logic [31:0] store [2**IW];
    logic [3:0] cmd;
    logic [2:0] cl_q, cl_d, bl_q, bl_d;
    logic burst_q, burst_d, wr_q, wr_d, sref_q, sref_d, hi_q, hi_d;
    logic [COL_BITS-1:0] col_q, col_d, col;
    logic [1:0] bank_q, bank_d;
    logic [8:0] rem_q, rem_d;
    logic v0_q, v0_d, v1_q, v1_d;
    logic [31:0] s0_q, s0_d, s1_q, s1_d, dout_q, dout_d;
    logic [3:0] dqm_q, doe_q, doe_d, ben;
    logic acc, rd_acc, wen;

    // ************************************************************
    // command decode and burst sequencing
    // ************************************************************
    always_comb begin
        cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
        cl_d = cl_q;
        bl_d = bl_q;
        burst_d = burst_q;
        wr_d = wr_q;
        col_d = col_q;
        bank_d = bank_q;
        rem_d = rem_q;
        sref_d = sref_q;
        hi_d = 1'b0;
        acc = 1'b0;
        col = col_q;
        if (sref_q) begin
            // exit begins on the second edge that sees cke high
            hi_d = bus.cke;
            if (bus.cke && hi_q) begin
                sref_d = 1'b0;
            end
        end else if (cmd == sdcl_pkg::SDCL_REF && !bus.cke) begin
            sref_d = 1'b1;
            burst_d = 1'b0;
        end else if (cmd == sdcl_pkg::SDCL_MRS) begin
            cl_d = bus.addr[sdcl_pkg::MODE_CL_LSB +: 3];
            bl_d = bus.addr[sdcl_pkg::MODE_BL_LSB +: 3];
        end else if (cmd == sdcl_pkg::SDCL_RD || cmd == sdcl_pkg::SDCL_WR) begin
            acc = 1'b1;
            col = bus.addr[COL_BITS-1:0];
            bank_d = bus.ba;
            wr_d = cmd == sdcl_pkg::SDCL_WR;
            rem_d = 9'((1 << bl_q) - 1);
        end else if (cmd == sdcl_pkg::SDCL_BST) begin
            // terminating edge neither stores nor fetches
            burst_d = 1'b0;
        end else if (burst_q) begin
            acc = 1'b1;
        end
        if (acc) begin
            col_d = col + 1'b1;
            burst_d = (bl_q == sdcl_pkg::MODE_BL_FULL) || rem_d != 9'h000;
            if (bl_q != sdcl_pkg::MODE_BL_FULL && burst_q && !(
                cmd == sdcl_pkg::SDCL_RD || cmd == sdcl_pkg::SDCL_WR)) begin
                rem_d = rem_q - 1'b1;
                burst_d = rem_q != 9'h001;
            end
        end
        wen = acc & wr_d;
        rd_acc = acc & ~wr_d;
        ben = ~bus.dqm;
    end

    // ************************************************************
    // read pipeline: two stages, tap chosen by latency
    // ************************************************************
    always_comb begin
        v0_d = rd_acc;
        s0_d = store[{bank_d, col}];
        v1_d = v0_q;
        s1_d = s0_q;
        // already fetched words still drain after a terminate
        if (cl_q == 3'h2) begin
            dout_d = s0_q;
            doe_d = {4{v0_q}};
        end else begin
            dout_d = s1_q;
            doe_d = {4{v1_q}};
        end
        // mask sampled one edge back, lanes drop at the second edge
        doe_d = doe_d & ~dqm_q;
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (wen && ben[i]) begin
                store[{bank_d, col}][8*i +: 8] <= bus.dq[8*i +: 8];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cl_q <= sdcl_pkg::CL_RESET;
            bl_q <= sdcl_pkg::BL_RESET;
            burst_q <= 1'b0;
            wr_q <= 1'b0;
            col_q <= '0;
            bank_q <= 2'h0;
            rem_q <= 9'h000;
            sref_q <= 1'b0;
            hi_q <= 1'b0;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            s0_q <= 32'h0000_0000;
            s1_q <= 32'h0000_0000;
            dout_q <= 32'h0000_0000;
            doe_q <= 4'h0;
            dqm_q <= 4'h0;
        end else begin
            cl_q <= cl_d;
            bl_q <= bl_d;
            burst_q <= burst_d;
            wr_q <= wr_d;
            col_q <= col_d;
            bank_q <= bank_d;
            rem_q <= rem_d;
            sref_q <= sref_d;
            hi_q <= hi_d;
            v0_q <= v0_d;
            v1_q <= v1_d;
            s0_q <= s0_d;
            s1_q <= s1_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            dqm_q <= bus.dqm;
        end
    end

    assign bus.dq_m = dout_q;
    assign bus.dq_m_oe = doe_q;
endmodule

`default_nettype wire

// ===== hdl/sdcl_ctl.sv
/*
 * Controller end of the link: buffers user requests, initialises the
 * memory, refreshes it, runs single-word accesses with auto precharge
 * and enters and leaves self refresh.
 * Assumes the memory shares clk; its inputs need no synchroniser.
 */
`default_nettype none

module sdcl_ctl #(
    parameter int CAS_LAT = 3,
    parameter int INIT_WAIT = 16,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    sdcl_if.ctl bus,
    // requests
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [20:0] req_addr,
    input wire logic [31:0] req_data,
    input wire logic [3:0] req_mask,
    // read answers
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    // power and status
    input wire logic sleep_req,
    output logic sleep_ack,
    output logic init_done
);
    localparam int FW = 58;
    localparam int WT_W = 16;
    localparam int WR_CYC = (CAS_LAT == 3) ? sdcl_pkg::WR_CL3_CYC
                                           : sdcl_pkg::WR_CL2_CYC;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_PRECH = 4'h1,
        ST_MODE = 4'h2,
        ST_IDLE = 4'h3,
        ST_ACT = 4'h4,
        ST_COL = 4'h5,
        ST_HOLD = 4'h6,
        ST_REFRESH = 4'h7,
        ST_SLEEP_IN = 4'h8,
        ST_SLEEP = 4'h9,
        ST_WAKE = 4'ha
    } sdcl_state_t;

    sdcl_state_t state_q, state_d, after_q, after_d;
    logic [WT_W-1:0] wt_q, wt_d;
    logic [3:0] cmd_q, cmd_d;
    logic cke_q, cke_d;
    logic [1:0] ba_q, ba_d;
    logic [10:0] addr_q, addr_d;
    logic [3:0] dqm_q, dqm_d;
    logic [31:0] dqc_q, dqc_d;
    logic dqc_oe_q, dqc_oe_d;
    logic [FW-1:0] cur_q, cur_d, fifo_data;
    logic fifo_valid, pop;
    logic [10:0] ref_cnt_q, ref_cnt_d;
    logic ref_due_q, ref_due_d, ref_issue, ref_wrap;
    logic [7:0] cap_q, cap_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [31:0] rsp_data_q, rsp_data_d;
    logic sleep_ack_q, sleep_ack_d, init_q, init_d;

    // ************************************************************
    // request buffer
    // ************************************************************
    sdcl_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) sdcl_fifo_i (
        .clk(clk),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_addr, req_data, req_mask}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // ************************************************************
    // refresh pacing
    // ************************************************************
    always_comb begin
        ref_wrap = 1'b0;
        if (state_q == ST_SLEEP) begin
            ref_cnt_d = 11'h000;
        end else if (ref_cnt_q == 11'(sdcl_pkg::REF_INTERVAL_CYC - 1)) begin
            ref_cnt_d = 11'h000;
            ref_wrap = 1'b1;
        end else begin
            ref_cnt_d = ref_cnt_q + 1'b1;
        end
        // a new due tick wins over the clear
        ref_due_d = ref_wrap | (ref_due_q & ~ref_issue);
    end

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        after_d = after_q;
        wt_d = wt_q;
        cmd_d = sdcl_pkg::SDCL_NOP;
        cke_d = cke_q;
        ba_d = ba_q;
        addr_d = addr_q;
        dqm_d = 4'h0;
        dqc_d = dqc_q;
        dqc_oe_d = 1'b0;
        cur_d = cur_q;
        pop = 1'b0;
        ref_issue = 1'b0;
        init_d = init_q;
        sleep_ack_d = sleep_ack_q;
        cap_d = {cap_q[6:0], 1'b0};
        rsp_valid_d = cap_q[CAS_LAT];
        rsp_data_d = cap_q[CAS_LAT] ? bus.dq : rsp_data_q;
        // memory samples the mask two edges before the data edge:
        // one cycle after RD at latency 3, together with RD at 2
        if (CAS_LAT > 2 && cap_q[(CAS_LAT > 2) ? CAS_LAT - 3 : 0]) begin
            dqm_d = cur_q[3:0];
        end
        case (state_q)
            ST_RESET: begin
                state_d = ST_HOLD;
                wt_d = WT_W'(INIT_WAIT - 1);
                after_d = ST_PRECH;
            end
            ST_PRECH: begin
                cmd_d = sdcl_pkg::SDCL_PRE;
                addr_d = 11'h000;
                addr_d[sdcl_pkg::AP_BIT] = 1'b1;
                state_d = ST_HOLD;
                wt_d = WT_W'(sdcl_pkg::RP_CYC - 1);
                after_d = ST_MODE;
            end
            ST_MODE: begin
                cmd_d = sdcl_pkg::SDCL_MRS;
                addr_d = 11'h000;
                addr_d[sdcl_pkg::MODE_CL_LSB +: 3] = 3'(CAS_LAT);
                state_d = ST_HOLD;
                wt_d = WT_W'(sdcl_pkg::MRD_CYC - 1);
                after_d = ST_IDLE;
                init_d = 1'b1;
            end
            ST_IDLE: begin
                sleep_ack_d = 1'b0;
                if (ref_due_q) begin
                    state_d = ST_REFRESH;
                end else if (sleep_req) begin
                    state_d = ST_SLEEP_IN;
                end else if (fifo_valid) begin
                    pop = 1'b1;
                    cur_d = fifo_data;
                    state_d = ST_ACT;
                end
            end
            ST_REFRESH: begin
                cmd_d = sdcl_pkg::SDCL_REF;
                ref_issue = 1'b1;
                state_d = ST_HOLD;
                wt_d = WT_W'(sdcl_pkg::ROW_CYCLE_INTERVAL_CYC - 1);
                after_d = ST_IDLE;
            end
            ST_SLEEP_IN: begin
                cmd_d = sdcl_pkg::SDCL_REF;
                cke_d = 1'b0;
                sleep_ack_d = 1'b1;
                state_d = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // two edges for the exit to start, then a full row cycle
                cke_d = 1'b1;
                state_d = ST_HOLD;
                wt_d = WT_W'(sdcl_pkg::SREX_EDGE +
                    sdcl_pkg::ROW_CYCLE_INTERVAL_CYC - 1);
                after_d = ST_IDLE;
            end
            ST_ACT: begin
                cmd_d = sdcl_pkg::SDCL_ACT;
                ba_d = cur_q[56:55];
                addr_d = cur_q[54:44];
                state_d = ST_HOLD;
                wt_d = WT_W'(sdcl_pkg::RCD_CYC - 1);
                after_d = ST_COL;
            end
            ST_COL: begin
                addr_d = {3'h0, cur_q[43:36]};
                addr_d[sdcl_pkg::AP_BIT] = 1'b1;
                state_d = ST_HOLD;
                after_d = ST_IDLE;
                if (cur_q[57]) begin
                    cmd_d = sdcl_pkg::SDCL_WR;
                    dqc_d = cur_q[35:4];
                    dqc_oe_d = 1'b1;
                    dqm_d = cur_q[3:0];
                    // data edge, recovery, then the auto precharge
                    wt_d = WT_W'(WR_CYC + sdcl_pkg::RP_CYC);
                end else begin
                    cmd_d = sdcl_pkg::SDCL_RD;
                    cap_d[0] = 1'b1;
                    if (CAS_LAT == 2) begin
                        dqm_d = cur_q[3:0];
                    end
                    // read data is gone before any later write drives
                    wt_d = WT_W'(CAS_LAT + sdcl_pkg::RP_CYC);
                end
            end
            ST_HOLD: begin
                // every wait ends in the idle state or a single command,
                // so column commands never come closer than one clock
                wt_d = wt_q - 1'b1;
                if (wt_q == 16'h0001) begin
                    state_d = after_q;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RESET;
            after_q <= ST_RESET;
            wt_q <= 16'h0000;
            cmd_q <= sdcl_pkg::SDCL_NOP;
            cke_q <= 1'b1;
            ba_q <= 2'h0;
            addr_q <= 11'h000;
            dqm_q <= 4'h0;
            dqc_q <= 32'h0000_0000;
            dqc_oe_q <= 1'b0;
            cur_q <= '0;
            ref_cnt_q <= 11'h000;
            ref_due_q <= 1'b0;
            cap_q <= 8'h00;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h0000_0000;
            sleep_ack_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            wt_q <= wt_d;
            cmd_q <= cmd_d;
            cke_q <= cke_d;
            ba_q <= ba_d;
            addr_q <= addr_d;
            dqm_q <= dqm_d;
            dqc_q <= dqc_d;
            dqc_oe_q <= dqc_oe_d;
            cur_q <= cur_d;
            ref_cnt_q <= ref_cnt_d;
            ref_due_q <= ref_due_d;
            cap_q <= cap_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            sleep_ack_q <= sleep_ack_d;
            init_q <= init_d;
        end
    end

    assign bus.cke = cke_q;
    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_q;
    assign bus.ba = ba_q;
    assign bus.addr = addr_q;
    assign bus.dqm = dqm_q;
    assign bus.dq_c = dqc_q;
    assign bus.dq_c_oe = dqc_oe_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign sleep_ack = sleep_ack_q;
    assign init_done = init_q;
endmodule

`default_nettype wire

// ===== sim/sdcl_asserts.sv
/*
 * Timing checker for the pins between controller and memory.
 * Assumes CAS latency 3 and burst length 1, as the controller sets them.
 */
`default_nettype none

module sdcl_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    // data pins
    input wire logic [3:0] dqm,
    input wire logic dq_c_oe,
    input wire logic [3:0] dq_m_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cmd;
    logic [11:0] ref_gap_q;
    logic [11:0] ref_gap_d;

    assign cmd = {cs_n, ras_n, cas_n, we_n};

    // ****************************************
    // refresh spacing, parked in self refresh
    // ****************************************
    always_comb begin
        if (cmd == sdcl_pkg::SDCL_REF || !cke) begin
            ref_gap_d = 12'h000;
        end else begin
            ref_gap_d = ref_gap_q + 12'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_gap_q <= 12'h000;
        end else begin
            ref_gap_q <= ref_gap_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RD_MASK: assert property ((dq_m_oe & $past(dqm, 2)) == 4'h0)
        else $error("masked read lane still driven");
    AST_RD_LAT: assert property (
        cmd == sdcl_pkg::SDCL_RD |-> ##3 dq_m_oe == ~$past(dqm, 2))
        else $error("read data not on bus at latency");
    AST_WR_DATA: assert property (dq_c_oe == (cmd == sdcl_pkg::SDCL_WR))
        else $error("write data not aligned with write");
    AST_WR_RECOV: assert property (
        cmd == sdcl_pkg::SDCL_WR |=> (cmd == sdcl_pkg::SDCL_NOP) [*4])
        else $error("command too soon after write");
    AST_RD_REACT: assert property (
        cmd == sdcl_pkg::SDCL_RD |=> (cmd != sdcl_pkg::SDCL_ACT) [*7])
        else $error("bank reopened before precharge done");
    AST_PRE_WAIT: assert property (
        cmd == sdcl_pkg::SDCL_PRE |=> (cmd == sdcl_pkg::SDCL_NOP) [*2])
        else $error("command inside precharge time");
    AST_SR_HOLD: assert property (!cke |=> cmd == sdcl_pkg::SDCL_NOP)
        else $error("command while clock gated");
    AST_SR_EXIT: assert property (
        $rose(cke) |-> (cmd == sdcl_pkg::SDCL_NOP) [*8]
        ##1 (cmd == sdcl_pkg::SDCL_NOP) [*3])
        else $error("command too soon after self refresh exit");
    AST_REF_GAP: assert property (
        ref_gap_q <= 12'(sdcl_pkg::REF_INTERVAL_CYC + 32))
        else $error("refresh overdue");
    AST_NO_CLASH: assert property (!(dq_c_oe && dq_m_oe != 4'h0))
        else $error("both ends drive data");

    COV_RD_MASK: cover property (cmd == sdcl_pkg::SDCL_RD ##1 dqm != 4'h0);
    COV_WR_MASK: cover property (cmd == sdcl_pkg::SDCL_WR && dqm != 4'h0);
    COV_SR_EXIT: cover property ($rose(cke));
endmodule

`default_nettype wire

// ===== sim/sdcl_cmd_latency_timing_tb.sv
/*
 * Bench joining controller and memory over the link bundle.
 * Assumes default parameters, an 8 ns clock, user side driven here.
 */
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    mismatches++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module sdcl_cmd_latency_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [20:0] req_addr = 21'h000000;
    logic [31:0] req_data = 32'h00000000;
    logic [3:0] req_mask = 4'h0;
    logic sleep_req = 1'b0;
    logic req_ready, rsp_valid, sleep_ack, init_done;
    logic [31:0] rsp_data;
    logic full_seen = 1'b0;
    logic [31:0] rq[$];
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;

    sdcl_if bus_if ();
    sdcl_mem sdcl_mem_i (.clk(clk), .rst(rst), .bus(bus_if));
    sdcl_ctl sdcl_ctl_i (.clk(clk), .rst(rst), .bus(bus_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_mask(req_mask),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sleep_req(sleep_req),
        .sleep_ack(sleep_ack), .init_done(init_done));
    sdcl_asserts sdcl_asserts_i (.clk(clk), .rst(rst), .cke(bus_if.cke),
        .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
        .we_n(bus_if.we_n), .dqm(bus_if.dqm), .dq_c_oe(bus_if.dq_c_oe),
        .dq_m_oe(bus_if.dq_m_oe));

    always #4 clk = ~clk;

    // ****************************************
    // monitors and run limit
    // ****************************************
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) rq.push_back(rsp_data);
        if (req_valid && req_ready === 1'b0) full_seen = 1'b1;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [20:0] adr(input int i);
        return {2'(i), 11'h0a5, 8'(i)};
    endfunction

    // valid stays up between pushes; entered at a rising edge
    task automatic push(input logic w, input logic [20:0] a,
                        input logic [31:0] d, input logic [3:0] m);
        logic ok;
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_data = d;
        req_mask = m;
        ok = 1'b0;
        while (ok !== 1'b1) begin
            @(negedge clk);
            ok = req_ready;
            @(posedge clk);
        end
    endtask

    task automatic wait_rsp(input int n);
        for (int k = 0; k < 600 && rq.size() < n; k++) @(posedge clk);
    endtask

    task automatic rd_one(input logic [20:0] a, input logic [3:0] m,
                          output logic [31:0] got);
        rq.delete();
        @(posedge clk);
        push(1'b0, a, 32'h00000000, m);
        #1 req_valid = 1'b0;
        wait_rsp(1);
        got = (rq.size() == 0) ? 32'hxxxxxxxx : rq[0];
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_stream();
        logic [31:0] w;
        rq.delete();
        @(posedge clk);
        for (int i = 0; i < 20; i++) push(1'b1, adr(i), 32'h5a000000 + i, 4'h0);
        for (int i = 0; i < 20; i++) push(1'b0, adr(i), 32'h00000000, 4'h0);
        #1 req_valid = 1'b0;
        wait_rsp(20);
        `CHK("fifo full", 1'b1, full_seen)
        for (int i = 0; i < 20; i++) begin
            w = (i < rq.size()) ? rq[i] : 32'hxxxxxxxx;
            `CHK("stream", 32'h5a000000 + i, w)
        end
    endtask

    task automatic t_masks();
        logic [31:0] got;
        @(posedge clk);
        push(1'b1, adr(40), 32'h11223344, 4'h0);
        push(1'b1, adr(40), 32'haabbccdd, 4'h6);
        #1 req_valid = 1'b0;
        rd_one(adr(40), 4'h0, got);
        `CHK("wr mask", 32'haa2233dd, got)
        rd_one(adr(40), 4'h3, got);
        `CHK("rd mask", 32'haa220000, got)
        rd_one(adr(40), 4'hf, got);
        `CHK("rd mask all", 32'h00000000, got)
    endtask

    task automatic t_sleep();
        logic [31:0] got;
        @(posedge clk);
        #1 sleep_req = 1'b1;
        for (int k = 0; k < 3000 && sleep_ack !== 1'b1; k++) @(posedge clk);
        repeat (20) @(posedge clk);
        #1;
        `CHK("clock gate", 1'b0, bus_if.cke)
        `CHK("sleep ack", 1'b1, sleep_ack)
        sleep_req = 1'b0;
        for (int k = 0; k < 100 && sleep_ack !== 1'b0; k++) @(posedge clk);
        #1;
        `CHK("wake ack", 1'b0, sleep_ack)
        rd_one(adr(3), 4'h0, got);
        `CHK("after exit", 32'h5a000003, got)
    endtask

    task automatic t_refresh();
        logic [31:0] got;
        repeat (4200) @(posedge clk);
        rd_one(adr(5), 4'h0, got);
        `CHK("retained", 32'h5a000005, got)
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (int k = 0; k < 100 && init_done !== 1'b1; k++) @(posedge clk);
        #1;
        `CHK("init", 1'b1, init_done)
        t_stream();
        t_masks();
        t_sleep();
        t_refresh();
        tally_and_finish();
    end
endmodule

`default_nettype wire
